// File: rtl/hs_drv_pkg.sv
// Constants for the two-channel high-side driver control block.
// Assumes the host reaches registers by their 8-bit offset on the die bus.
package hs_drv_pkg;
	// Host-side bases; the block itself decodes only the offset
	localparam logic [15:0] BLOCKING_BASE    = 16'h0200;
	localparam logic [15:0] NONBLOCKING_BASE = 16'h0300;

	localparam logic [7:0] CTRL_OFFSET   = 8'h28;
	localparam logic [7:0] STATUS_OFFSET = 8'h29;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Control fields
	localparam int DRV1_ON_BIT           = 0;
	localparam int DRV2_ON_BIT           = 1;
	localparam int DRV1_PWM_EN_BIT       = 2;
	localparam int DRV2_PWM_EN_BIT       = 3;
	localparam int DRV1_PWM_SEL_BIT      = 4;
	localparam int DRV2_PWM_SEL_BIT      = 5;
	localparam int OV_CUTOFF_EN_BIT      = 6;
	localparam int OT_IRQ_EN_BIT         = 7;

	// Status fields
	localparam int DRV1_OPEN_LOAD_BIT    = 0;
	localparam int DRV2_OPEN_LOAD_BIT    = 1;
	localparam int DRV1_CUR_LIMIT_BIT    = 2;
	localparam int DRV2_CUR_LIMIT_BIT    = 3;
	localparam int OT_CONDITION_BIT      = 7;

	localparam int SYNC_STAGES           = 3;
endpackage : hs_drv_pkg

// File: rtl/analog_sense_sync.sv
// Three-stage synchroniser with agreement filter for analog sense inputs.
// Assumes inputs are asynchronous levels from the analog die.
`timescale 1ns/1ps
module analog_sense_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] clean
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire  [WIDTH-1:0] next_clean;

	// Change taken only when the last two stages agree
	assign next_clean = (stage2 & stage3) | (clean & (stage2 ^ stage3));

	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			clean  <= '0;
		end else begin
			stage1 <= raw;
			stage2 <= stage1;
			stage3 <= stage2;
			clean  <= next_clean;
		end
	end
endmodule : analog_sense_sync

// File: rtl/high_side_driver_control.sv
// Control and protection logic for two high-side output drivers.
// Assumes PWM channels come from same-clock logic; sense inputs are async.
`timescale 1ns/1ps
module high_side_driver_control (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic [1:0] pwm_channel,
	input  wire logic       drv_overtemp_sense,
	input  wire logic       overvoltage_condition,
	input  wire logic [1:0] open_load_sense,
	input  wire logic [1:0] current_limit_sense,
	output logic            drv1_on,
	output logic            drv2_on,
	output logic            drv_irq
);
	logic [7:0] output_driver_control;
	logic       ot_shutdown;
	logic       hv_shutdown;
	logic       drv_overtemp_flag;
	logic       ot_prev;
	logic [5:0] sense_clean;

	wire       ot_cond;
	wire       hv_cond;
	wire [1:0] ol_cond;
	wire [1:0] cl_cond;
	wire       ctrl_wr;
	wire       status_rd;
	wire       ot_event;
	wire       next_ot_shutdown;
	wire       next_hv_shutdown;
	wire       next_flag;
	wire       next_drv1_on;
	wire       next_drv2_on;
	wire [7:0] output_driver_status;
	wire [7:0] next_rdata;

	// Gate for one driver from its control bits and the PWM channels
	function automatic logic drive_gate(
		input logic       enable,
		input logic       pwm_en,
		input logic       pwm_sel,
		input logic [1:0] pwm_ch,
		input logic       shutdown
	);
		logic level;
		level = pwm_sel ? pwm_ch[1] : pwm_ch[0];
		drive_gate = enable & ~shutdown & (~pwm_en | level);
	endfunction : drive_gate

	analog_sense_sync #(
		.WIDTH(6)
	) u_sense_sync (
		.clk  (clk),
		.rst  (rst),
		.raw  ({current_limit_sense, open_load_sense, overvoltage_condition, drv_overtemp_sense}),
		.clean(sense_clean)
	);

	assign ot_cond = sense_clean[0];
	assign hv_cond = sense_clean[1];
	assign ol_cond = sense_clean[3:2];
	assign cl_cond = sense_clean[5:4];

	assign ctrl_wr   = reg_wr & (reg_addr == hs_drv_pkg::CTRL_OFFSET);
	assign status_rd = reg_rd & (reg_addr == hs_drv_pkg::STATUS_OFFSET);
	assign ot_event  = ot_cond & ~ot_prev;

	// Set wins: a write during the condition leaves the latch set
	assign next_ot_shutdown = ot_cond | (ot_shutdown & ~ctrl_wr);
	assign next_hv_shutdown = (hv_cond & output_driver_control[hs_drv_pkg::OV_CUTOFF_EN_BIT])
		| (hv_shutdown & ~(ctrl_wr & ~hv_cond));
	assign next_flag = ot_event | (drv_overtemp_flag & ~status_rd);

	// No low-power mode term: drivers keep running in sleep and stop
	assign next_drv1_on = drive_gate(output_driver_control[hs_drv_pkg::DRV1_ON_BIT],
		output_driver_control[hs_drv_pkg::DRV1_PWM_EN_BIT],
		output_driver_control[hs_drv_pkg::DRV1_PWM_SEL_BIT],
		pwm_channel, next_ot_shutdown | next_hv_shutdown);
	assign next_drv2_on = drive_gate(output_driver_control[hs_drv_pkg::DRV2_ON_BIT],
		output_driver_control[hs_drv_pkg::DRV2_PWM_EN_BIT],
		output_driver_control[hs_drv_pkg::DRV2_PWM_SEL_BIT],
		pwm_channel, next_ot_shutdown | next_hv_shutdown);

	// Open load only counts while the output is actually driven
	assign output_driver_status = {ot_shutdown, 3'b000, cl_cond,
		ol_cond[1] & drv2_on, ol_cond[0] & drv1_on};

	assign next_rdata = (reg_addr == hs_drv_pkg::CTRL_OFFSET)   ? output_driver_control :
	                    (reg_addr == hs_drv_pkg::STATUS_OFFSET) ? output_driver_status  :
	                    hs_drv_pkg::UNMAPPED_READ;

	always_ff @(posedge clk) begin
		if (rst) begin
			output_driver_control <= hs_drv_pkg::CTRL_RESET;
		end else if (ctrl_wr) begin
			output_driver_control <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ot_shutdown       <= 1'b0;
			hv_shutdown       <= 1'b0;
			drv_overtemp_flag <= 1'b0;
			ot_prev           <= 1'b0;
			drv1_on           <= 1'b0;
			drv2_on           <= 1'b0;
			drv_irq           <= 1'b0;
		end else begin
			ot_shutdown       <= next_ot_shutdown;
			hv_shutdown       <= next_hv_shutdown;
			drv_overtemp_flag <= next_flag;
			ot_prev           <= ot_cond;
			drv1_on           <= next_drv1_on;
			drv2_on           <= next_drv2_on;
			drv_irq           <= next_flag & output_driver_control[hs_drv_pkg::OT_IRQ_EN_BIT];
		end
	end

	// Read data held until the next read
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= hs_drv_pkg::UNMAPPED_READ;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	a_ol_report: assert property (@(posedge clk) disable iff (rst)
		(ol_cond[0] && drv1_on) |-> output_driver_status[0])
		else $error("open load not reported");
	// Checked at the read data so the capture path is covered too
	a_ol_gated: assert property (@(posedge clk) disable iff (rst)
		status_rd |=> !(reg_rdata[0] && !$past(drv1_on)) && !(reg_rdata[1] && !$past(drv2_on)))
		else $error("open load reported while off");
	a_cl_report: assert property (@(posedge clk) disable iff (rst)
		output_driver_status[3:2] == cl_cond)
		else $error("current limit bits wrong");
	a_ot_cutoff: assert property (@(posedge clk) disable iff (rst)
		ot_cond |=> !drv1_on && !drv2_on && ot_shutdown)
		else $error("overtemp did not cut drivers");
	a_ot_irq: assert property (@(posedge clk) disable iff (rst)
		ot_cond && !ot_prev |=> drv_overtemp_flag)
		else $error("overtemp event not latched");
	a_ot_status: assert property (@(posedge clk) disable iff (rst)
		ot_cond |=> output_driver_status[7])
		else $error("overtemp status missing");
	a_ot_hold: assert property (@(posedge clk) disable iff (rst)
		ot_shutdown && !ctrl_wr |=> ot_shutdown)
		else $error("overtemp shutdown released without write");
	a_hv_cutoff: assert property (@(posedge clk) disable iff (rst)
		hv_cond && output_driver_control[6] |=> !drv1_on && !drv2_on)
		else $error("armed overvoltage did not cut drivers");
	a_hv_ignore: assert property (@(posedge clk) disable iff (rst)
		!output_driver_control[6] && !hv_shutdown |=> !hv_shutdown)
		else $error("overvoltage acted while disarmed");
	a_hv_release: assert property (@(posedge clk) disable iff (rst)
		hv_shutdown && ctrl_wr && !hv_cond |=> !hv_shutdown)
		else $error("overvoltage shutdown not released");
	a_irq_mask: assert property (@(posedge clk) disable iff (rst)
		drv_irq |-> drv_overtemp_flag && $past(output_driver_control[7]))
		else $error("interrupt escaped mask");
	a_pwm_follow: assert property (@(posedge clk) disable iff (rst)
		output_driver_control[2] && !output_driver_control[4] && !pwm_channel[0] |=> !drv1_on)
		else $error("driver one ignored PWM low");
	a_drv_enable: assert property (@(posedge clk) disable iff (rst)
		drv2_on |-> $past(output_driver_control[1]) && !$past(ot_cond))
		else $error("driver two on while disabled");
	a_read_clear: assert property (@(posedge clk) disable iff (rst)
		status_rd && !ot_event |=> !drv_overtemp_flag)
		else $error("status read kept flag");
	a_status_read: assert property (@(posedge clk) disable iff (rst)
		status_rd |=> reg_rdata == $past(output_driver_status))
		else $error("status read data wrong");
	a_ctrl_read: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == hs_drv_pkg::CTRL_OFFSET |=> reg_rdata == $past(output_driver_control))
		else $error("control read data wrong");
	a_ot_release: assert property (@(posedge clk) disable iff (rst)
		ot_shutdown && ctrl_wr && !ot_cond |=> !ot_shutdown)
		else $error("overtemp shutdown not released");
	a_hv_hold: assert property (@(posedge clk) disable iff (rst)
		hv_shutdown && !(ctrl_wr && !hv_cond) |=> hv_shutdown)
		else $error("overvoltage shutdown released early");
	a_irq_raise: assert property (@(posedge clk) disable iff (rst)
		ot_event && output_driver_control[hs_drv_pkg::OT_IRQ_EN_BIT] |=> drv_irq)
		else $error("unmasked overtemp gave no interrupt");
	a_pwm_select: assert property (@(posedge clk) disable iff (rst)
		drv2_on && $past(output_driver_control[hs_drv_pkg::DRV2_PWM_EN_BIT])
		|-> $past(output_driver_control[hs_drv_pkg::DRV2_PWM_SEL_BIT] ? pwm_channel[1] : pwm_channel[0]))
		else $error("driver two followed wrong channel");
	a_drv_gate: assert property (@(posedge clk) disable iff (rst)
		drv1_on |-> $past(output_driver_control[hs_drv_pkg::DRV1_ON_BIT]) && !ot_shutdown && !hv_shutdown)
		else $error("driver one on without cause");
	// No mode input exists, so driver one, enabled with PWM off, must simply stay on
	a_drv_run: assert property (@(posedge clk) disable iff (rst)
		$past(output_driver_control[hs_drv_pkg::DRV1_ON_BIT]) && !$past(output_driver_control[hs_drv_pkg::DRV1_PWM_EN_BIT])
		&& !ot_shutdown && !hv_shutdown |-> drv1_on)
		else $error("enabled driver one not on");
	a_reset_ctrl: assert property (@(posedge clk) disable iff (rst)
		$past(rst) |-> output_driver_control == 8'h00 && !drv1_on && !drv2_on)
		else $error("control not cleared by reset");
endmodule : high_side_driver_control

// File: bench/led_load_model.sv
// Load model for the two high-side outputs: open or shorted load per driver.
// Assumes the bench sets open or shorted loads; senses are plain levels.
`timescale 1ns/1ps
module led_load_model (
	input  wire logic       drv1_on,
	input  wire logic       drv2_on,
	input  wire logic [1:0] load_open,
	input  wire logic [1:0] load_short,
	output logic      [1:0] open_load_sense,
	output logic      [1:0] current_limit_sense
);
	// An off driver carries no current, so the raw sense reads open load
	assign open_load_sense     = ~{drv2_on, drv1_on} | load_open;
	assign current_limit_sense = {drv2_on, drv1_on} & load_short;
endmodule : led_load_model

// File: bench/high_side_driver_control_bench.sv
// Self-checking bench for the high-side driver control block.
// Assumes the load model above and 8-bit offset strobe register access.
`timescale 1ns/1ps
module high_side_driver_control_bench;
	logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ot = 0, ov = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [1:0] pwm = 0, lopen = 0, lshort = 0, ol, cl;
	logic       d1, d2, irq;
	int         num_errors = 0, n_compared = 0, cycles = 0;
	always #2 clk = ~clk;
	high_side_driver_control dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pwm_channel(pwm), .drv_overtemp_sense(ot),
		.overvoltage_condition(ov), .open_load_sense(ol), .current_limit_sense(cl),
		.drv1_on(d1), .drv2_on(d2), .drv_irq(irq));
	led_load_model load (.drv1_on(d1), .drv2_on(d2), .load_open(lopen), .load_short(lshort),
		.open_load_sense(ol), .current_limit_sense(cl));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		cyc(1);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		chk(reg_rdata, exp);
	endtask : rd
	task outs(input logic [7:0] exp);
		chk({6'h0, d2, d1}, exp);
	endtask : outs
	task t_reset;
		outs(8'h00);
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		rd(8'h10, 8'h00);
	endtask : t_reset
	task t_enable;
		wr(8'h28, 8'h01);
		cyc(2);
		outs(8'h01);
		wr(8'h28, 8'h02);
		wr(8'h29, 8'hff);
		cyc(2);
		outs(8'h02);
		rd(8'h28, 8'h02);
	endtask : t_enable
	task t_pwm;
		pwm = 2'b01;
		wr(8'h28, 8'h2f);
		cyc(2);
		outs(8'h01);
		pwm = 2'b10;
		cyc(2);
		outs(8'h02);
		wr(8'h28, 8'h1f);
		cyc(2);
		outs(8'h01);
		pwm = 2'b00;
		wr(8'h28, 8'h03);
		cyc(2);
		outs(8'h03);
	endtask : t_pwm
	task t_sense;
		wr(8'h28, 8'h01);
		lopen = 2'b11;
		lshort = 2'b11;
		cyc(8);
		rd(8'h29, 8'h05);
		wr(8'h28, 8'h02);
		cyc(8);
		rd(8'h29, 8'h0a);
		wr(8'h28, 8'h05);
		cyc(8);
		rd(8'h29, 8'h00);
		lopen = 0;
		lshort = 0;
	endtask : t_sense
	task t_overtemp(input logic [7:0] ctrl, input logic exp_irq);
		wr(8'h28, ctrl);
		ot = 1;
		cyc(7);
		outs(8'h00);
		chk({7'h0, irq}, {7'h0, exp_irq});
		rd(8'h29, 8'h80);
		chk({7'h0, irq}, 8'h00);
		wr(8'h28, ctrl);
		cyc(2);
		outs(8'h00);
		ot = 0;
		cyc(7);
		outs(8'h00);
		wr(8'h28, 8'h03);
		cyc(2);
		outs(8'h03);
	endtask : t_overtemp
	task t_overvolt;
		wr(8'h28, 8'h03);
		ov = 1;
		cyc(7);
		outs(8'h03);
		wr(8'h28, 8'h43);
		cyc(3);
		outs(8'h00);
		wr(8'h28, 8'h43);
		cyc(3);
		outs(8'h00);
		ov = 0;
		cyc(7);
		outs(8'h00);
		wr(8'h28, 8'h43);
		cyc(3);
		outs(8'h03);
	endtask : t_overvolt
	task test_done;
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	// Whole run needs about 150 cycles; the ceiling leaves ample room
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		cyc(3);
		rst = 0;
		t_reset();
		t_enable();
		t_pwm();
		t_sense();
		t_overtemp(8'h83, 1'b1);
		t_overtemp(8'h03, 1'b0);
		t_overvolt();
		test_done();
	end
endmodule : high_side_driver_control_bench
